// *** hw/gpx_params.svh ***
// constants for the gpio expander register file and interrupt logic
`ifndef GPX_PARAMS_SVH
`define GPX_PARAMS_SVH

`define GPX_OFS_PIN_STATE 8'h00
`define GPX_OFS_OUTPUT_LEVEL 8'h01
`define GPX_OFS_INPUT_POLARITY_INVERT 8'h02
`define GPX_OFS_PIN_DIRECTION 8'h03
`define GPX_OFS_PULLUP_ENABLE 8'h04
`define GPX_OFS_IRQ_ENABLE 8'h05
`define GPX_OFS_OUTPUT_HIZ_CONTROL 8'h06
`define GPX_OFS_IRQ_PENDING 8'h07
`define GPX_OFS_RISE_EDGE_SELECT 8'h08
`define GPX_OFS_FALL_EDGE_SELECT 8'h09
`define GPX_OFS_GLITCH_FILTER_ENABLE 8'h0A

`define GPX_RST_OUTPUT_LEVEL 8'hFF
`define GPX_RST_INPUT_POLARITY_INVERT 8'h00
`define GPX_RST_PIN_DIRECTION 8'hFF
`define GPX_RST_PULLUP_ENABLE 8'h00
`define GPX_RST_IRQ_ENABLE 8'h00
`define GPX_RST_OUTPUT_HIZ_CONTROL 8'h00
`define GPX_RST_IRQ_PENDING 8'h00
`define GPX_RST_RISE_EDGE_SELECT 8'h00
`define GPX_RST_FALL_EDGE_SELECT 8'h00
`define GPX_RST_GLITCH_FILTER_ENABLE 8'hFF
`define GPX_UNMAPPED_READ 8'h00
`define GPX_ZERO_BYTE 8'h00

`define GPX_CLK_PERIOD_NS 100
`define GPX_FILT_TIME_NS 1075
`define GPX_FILT_CYC (((`GPX_FILT_TIME_NS) + (`GPX_CLK_PERIOD_NS) - 1) / (`GPX_CLK_PERIOD_NS))

`endif

// *** hw/gpx_pkg.sv ***
// shared types of the gpio expander
package gpx_pkg;
	typedef logic [7:0] gpx_byte_t;
	typedef logic [3:0] gpx_cnt_t;
endpackage

// *** hw/gpx_regs_irq.sv ***
// register file, pin control and per-pin interrupt logic of the gpio expander
// Operation
// - command byte offset selects register; offsets 0x00 to 0x0A are valid
// - input pin reads present level, complemented where polarity invert is set
// - output pin reads last written output level, even when three-stated
// - writes to pin state register are ignored, nothing changes
// - bit 7 maps to highest pin, bit 0 to lowest, in order
// - output level drives output pins, resets to 0xFF, reads stored value
// - polarity invert resets 0x00; 1 complements reported input, 0 true level
// - direction bit 0 is output, 1 input; resets 0xFF, all inputs
// - pull-up register resets 0x00; 1 enables pin pull-up, 0 disables
// - output pins never raise an input interrupt
// - disabled inputs never interrupt; interrupt enable resets 0x00
// - no edge bits: any edge sets; cleared by read or return to snapshot
// - rise only: rising edges set, filtered high over 1075ns; read clears
// - fall only: falling edges set, filtered low over 1075ns; read clears
// - filter on: edge counts after level holds over 1075ns; resets 0xFF
// - interrupt status register reports pending interrupt per pin
// - hiz control bit 1 releases that output driver to high impedance
// - filter on: pulses under 225ns never interrupt
`timescale 1ns/10ps
`include "gpx_params.svh"

module gpx_regs_irq (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_clk_link,
	input wire logic i_link_req,
	input wire logic i_link_write,
	input wire gpx_pkg::gpx_byte_t i_link_addr,
	input wire gpx_pkg::gpx_byte_t i_link_wdata,
	output logic o_link_busy,
	output logic o_link_done,
	output gpx_pkg::gpx_byte_t o_link_rdata,
	input wire gpx_pkg::gpx_byte_t i_io_pins,
	output gpx_pkg::gpx_byte_t o_io_pins_out,
	output gpx_pkg::gpx_byte_t o_io_pins_oe_n,
	output gpx_pkg::gpx_byte_t o_pullup_en,
	output logic o_irq_out,
	output logic o_irq_oe_n
);

	// link domain: reset synchroniser, request capture, answer pickup
	logic link_rst_meta_n;
	logic link_rst_n;
	logic link_req_tgl;
	logic link_busy;
	logic link_done;
	logic link_write_hold;
	gpx_pkg::gpx_byte_t link_addr_hold;
	gpx_pkg::gpx_byte_t link_wdata_hold;
	gpx_pkg::gpx_byte_t link_rdata;
	logic ack_s1;
	logic ack_s2;
	logic ack_s3;
	// sys domain
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic sys_ack_tgl;
	gpx_pkg::gpx_byte_t rd_hold;
	gpx_pkg::gpx_byte_t pin_s1;
	gpx_pkg::gpx_byte_t pin_sync;
	gpx_pkg::gpx_byte_t output_level;
	gpx_pkg::gpx_byte_t input_polarity_invert;
	gpx_pkg::gpx_byte_t pin_direction;
	gpx_pkg::gpx_byte_t pullup_enable;
	gpx_pkg::gpx_byte_t irq_enable;
	gpx_pkg::gpx_byte_t output_hiz_control;
	gpx_pkg::gpx_byte_t irq_pending;
	gpx_pkg::gpx_byte_t rise_edge_select;
	gpx_pkg::gpx_byte_t fall_edge_select;
	gpx_pkg::gpx_byte_t glitch_filter_enable;
	gpx_pkg::gpx_byte_t flt_lvl;
	gpx_pkg::gpx_byte_t flt_prev;
	gpx_pkg::gpx_byte_t snap_lvl;
	gpx_pkg::gpx_byte_t pin_state;
	gpx_pkg::gpx_byte_t set_vec;
	gpx_pkg::gpx_byte_t next_rdata;
	logic acc;
	logic wr_acc;
	logic rd_pin_state;
	logic irq_oe_n;

	// reset reaches the link side through two flops of its own clock
	always_ff @(posedge i_clk_link) begin
		link_rst_meta_n <= i_rst_n;
		link_rst_n <= link_rst_meta_n;
	end

	always_ff @(posedge i_clk_link) begin
		ack_s1 <= sys_ack_tgl;
		ack_s2 <= ack_s1;
		ack_s3 <= ack_s2;
	end

	// address and data stay frozen while busy, so the sys side may read them
	always_ff @(posedge i_clk_link) begin
		if (!link_rst_n) begin
			link_req_tgl <= 1'b0;
			link_busy <= 1'b0;
			link_done <= 1'b0;
			link_write_hold <= 1'b0;
			link_addr_hold <= `GPX_ZERO_BYTE;
			link_wdata_hold <= `GPX_ZERO_BYTE;
			link_rdata <= `GPX_ZERO_BYTE;
		end else begin
			link_done <= 1'b0;
			if (link_busy && (ack_s2 != ack_s3)) begin
				link_busy <= 1'b0;
				link_done <= 1'b1;
				link_rdata <= rd_hold;
			end else if (!link_busy && i_link_req) begin
				link_busy <= 1'b1;
				link_req_tgl <= ~link_req_tgl;
				link_write_hold <= i_link_write;
				link_addr_hold <= i_link_addr;
				link_wdata_hold <= i_link_wdata;
			end
		end
	end

	assign o_link_busy = link_busy;
	assign o_link_done = link_done;
	assign o_link_rdata = link_rdata;

	always_ff @(posedge i_clk_sys) begin
		req_s1 <= link_req_tgl;
		req_s2 <= req_s1;
		req_s3 <= req_s2;
		pin_s1 <= i_io_pins;
		pin_sync <= pin_s1;
	end

	assign acc = req_s2 ^ req_s3;
	assign wr_acc = acc && link_write_hold;
	assign rd_pin_state = acc && !link_write_hold && (link_addr_hold == `GPX_OFS_PIN_STATE);

	// pin_direction: 1 input shows the pin, 0 output shows the stored level
	assign pin_state = (pin_direction & (pin_sync ^ input_polarity_invert))
		| (~pin_direction & output_level);

	always_comb begin
		if (link_addr_hold == `GPX_OFS_PIN_STATE) begin
			next_rdata = pin_state;
		end else if (link_addr_hold == `GPX_OFS_OUTPUT_LEVEL) begin
			next_rdata = output_level;
		end else if (link_addr_hold == `GPX_OFS_INPUT_POLARITY_INVERT) begin
			next_rdata = input_polarity_invert;
		end else if (link_addr_hold == `GPX_OFS_PIN_DIRECTION) begin
			next_rdata = pin_direction;
		end else if (link_addr_hold == `GPX_OFS_PULLUP_ENABLE) begin
			next_rdata = pullup_enable;
		end else if (link_addr_hold == `GPX_OFS_IRQ_ENABLE) begin
			next_rdata = irq_enable;
		end else if (link_addr_hold == `GPX_OFS_OUTPUT_HIZ_CONTROL) begin
			next_rdata = output_hiz_control;
		end else if (link_addr_hold == `GPX_OFS_IRQ_PENDING) begin
			next_rdata = irq_pending;
		end else if (link_addr_hold == `GPX_OFS_RISE_EDGE_SELECT) begin
			next_rdata = rise_edge_select;
		end else if (link_addr_hold == `GPX_OFS_FALL_EDGE_SELECT) begin
			next_rdata = fall_edge_select;
		end else if (link_addr_hold == `GPX_OFS_GLITCH_FILTER_ENABLE) begin
			next_rdata = glitch_filter_enable;
		end else begin
			next_rdata = `GPX_UNMAPPED_READ;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sys_ack_tgl <= 1'b0;
			rd_hold <= `GPX_ZERO_BYTE;
		end else if (acc) begin
			sys_ack_tgl <= ~sys_ack_tgl;
			rd_hold <= next_rdata;
		end
	end

	// writes to pin state and irq pending fall through every branch
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			output_level <= `GPX_RST_OUTPUT_LEVEL;
			input_polarity_invert <= `GPX_RST_INPUT_POLARITY_INVERT;
			pin_direction <= `GPX_RST_PIN_DIRECTION;
			pullup_enable <= `GPX_RST_PULLUP_ENABLE;
			irq_enable <= `GPX_RST_IRQ_ENABLE;
			output_hiz_control <= `GPX_RST_OUTPUT_HIZ_CONTROL;
			rise_edge_select <= `GPX_RST_RISE_EDGE_SELECT;
			fall_edge_select <= `GPX_RST_FALL_EDGE_SELECT;
			glitch_filter_enable <= `GPX_RST_GLITCH_FILTER_ENABLE;
		end else if (wr_acc) begin
			if (link_addr_hold == `GPX_OFS_OUTPUT_LEVEL) begin
				output_level <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_INPUT_POLARITY_INVERT) begin
				input_polarity_invert <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_PIN_DIRECTION) begin
				pin_direction <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_PULLUP_ENABLE) begin
				pullup_enable <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_IRQ_ENABLE) begin
				irq_enable <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_OUTPUT_HIZ_CONTROL) begin
				output_hiz_control <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_RISE_EDGE_SELECT) begin
				rise_edge_select <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_FALL_EDGE_SELECT) begin
				fall_edge_select <= link_wdata_hold;
			end else if (link_addr_hold == `GPX_OFS_GLITCH_FILTER_ENABLE) begin
				glitch_filter_enable <= link_wdata_hold;
			end
		end
	end

	assign o_io_pins_out = output_level;
	assign o_io_pins_oe_n = pin_direction | output_hiz_control;
	assign o_pullup_en = pullup_enable;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			gpx_pkg::gpx_cnt_t cnt;
			logic en;
			logic both0;
			logic rise;
			logic fall;

			// filter only ever lets a level through after it held 11 cycles
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					cnt <= '0;
					flt_lvl[gi] <= 1'b0;
				end else if (!glitch_filter_enable[gi]) begin
					cnt <= '0;
					flt_lvl[gi] <= pin_sync[gi];
				end else if (pin_sync[gi] == flt_lvl[gi]) begin
					cnt <= '0;
				end else if (cnt == 4'(`GPX_FILT_CYC - 1)) begin
					cnt <= '0;
					flt_lvl[gi] <= pin_sync[gi];
				end else begin
					cnt <= cnt + 4'h1;
				end
			end

			assign en = irq_enable[gi] && pin_direction[gi];
			assign both0 = !rise_edge_select[gi] && !fall_edge_select[gi];
			assign rise = flt_lvl[gi] && !flt_prev[gi];
			assign fall = !flt_lvl[gi] && flt_prev[gi];
			assign set_vec[gi] = en && ((rise_edge_select[gi] && rise) || (fall_edge_select[gi] && fall)
				|| ((rise_edge_select[gi] == fall_edge_select[gi]) && (rise || fall)));

			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					flt_prev[gi] <= 1'b0;
					snap_lvl[gi] <= 1'b0;
					irq_pending[gi] <= 1'b0;
				end else begin
					flt_prev[gi] <= flt_lvl[gi];
					if (rd_pin_state) begin
						snap_lvl[gi] <= flt_lvl[gi];
					end
					if (!en) begin
						irq_pending[gi] <= 1'b0;
					end else if (both0 && (flt_lvl[gi] == snap_lvl[gi])) begin
						irq_pending[gi] <= 1'b0;
					end else if (set_vec[gi]) begin
						irq_pending[gi] <= 1'b1; // set beats a read in the same cycle
					end else if (rd_pin_state) begin
						irq_pending[gi] <= 1'b0;
					end
				end
			end

			AST_FILTER_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				($past(glitch_filter_enable[gi]) && $past(glitch_filter_enable[gi], 11) && $changed(flt_lvl[gi]))
				|-> ($past(pin_sync[gi], 1) == flt_lvl[gi]) && ($past(pin_sync[gi], 11) == flt_lvl[gi]))
				else $error("filtered level changed before holding long enough");

			sequence s_fall_in_rise_mode;
				en && rise_edge_select[gi] && !fall_edge_select[gi] && fall && !irq_pending[gi];
			endsequence

			AST_RISE_ONLY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				s_fall_in_rise_mode ##0 $stable(irq_enable[gi]) |=> !irq_pending[gi])
				else $error("falling edge set interrupt in rising-only mode");

			sequence s_rise_in_fall_mode;
				en && !rise_edge_select[gi] && fall_edge_select[gi] && rise && !irq_pending[gi];
			endsequence

			AST_FALL_ONLY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				s_rise_in_fall_mode ##0 $stable(irq_enable[gi]) |=> !irq_pending[gi])
				else $error("rising edge set interrupt in falling-only mode");

			AST_FILTER_BYPASS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
				!glitch_filter_enable[gi] |=> (flt_lvl[gi] == $past(pin_sync[gi])))
				else $error("unfiltered level lags the pin");
		end
	endgenerate

	// open drain: data pin held low, enable carries the assertion
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			irq_oe_n <= 1'b1;
		end else begin
			irq_oe_n <= ~|irq_pending;
		end
	end

	assign o_irq_out = 1'b0;
	assign o_irq_oe_n = irq_oe_n;

	sequence s_pin_state_read_quiet;
		rd_pin_state && (set_vec == `GPX_ZERO_BYTE);
	endsequence

	sequence s_pin_state_write;
		wr_acc && (link_addr_hold == `GPX_OFS_PIN_STATE);
	endsequence

	AST_RESET_VALUES: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> (pin_direction == `GPX_RST_PIN_DIRECTION) && (output_level == `GPX_RST_OUTPUT_LEVEL)
			&& (irq_enable == `GPX_RST_IRQ_ENABLE) && (glitch_filter_enable == `GPX_RST_GLITCH_FILTER_ENABLE))
		else $error("register reset value wrong");

	AST_PIN_STATE_WRITE_IGNORED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_pin_state_write |=> $stable(output_level) && $stable(pin_direction) && $stable(irq_enable)
			&& $stable(input_polarity_invert) && $stable(glitch_filter_enable))
		else $error("write to pin state changed a register");

	AST_OUTPUT_NO_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		##1 ((irq_pending & ~$past(pin_direction)) == `GPX_ZERO_BYTE))
		else $error("output pin holds an interrupt");

	AST_DISABLED_NO_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		##1 ((irq_pending & ~$past(irq_enable)) == `GPX_ZERO_BYTE))
		else $error("disabled pin holds an interrupt");

	AST_READ_CLEARS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_pin_state_read_quiet |=> (irq_pending == `GPX_ZERO_BYTE))
		else $error("pin state read did not clear interrupts");

	AST_IRQ_PIN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(|irq_pending) |=> !o_irq_oe_n ##0 (o_irq_out == 1'b0))
		else $error("interrupt pin not asserted");

	AST_PIN_STATE_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(rd_pin_state && (pin_direction == `GPX_ZERO_BYTE)) |=> (rd_hold == $past(output_level)))
		else $error("output pin read did not return output level");

	AST_LINK_ANSWER: assert property (@(posedge i_clk_link) disable iff (!link_rst_n)
		(!o_link_busy && i_link_req) |=> o_link_busy ##[1:40] o_link_done)
		else $error("link access not answered");

	AST_STATUS_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(acc && !link_write_hold && (link_addr_hold == `GPX_OFS_IRQ_PENDING)) |=> (rd_hold == $past(irq_pending)))
		else $error("status read did not return pending bits");

	AST_PIN_INPUT_READ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		rd_pin_state |=> (((rd_hold ^ $past(pin_sync) ^ $past(input_polarity_invert)) & $past(pin_direction))
			== `GPX_ZERO_BYTE))
		else $error("input pin read returned wrong level");

	AST_IRQ_RELEASE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(irq_pending == `GPX_ZERO_BYTE) |=> o_irq_oe_n)
		else $error("interrupt pin held with nothing pending");

	AST_WRITE_LANDS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(wr_acc && (link_addr_hold == `GPX_OFS_OUTPUT_LEVEL)) |=> (output_level == $past(link_wdata_hold)))
		else $error("output level write did not land");

	AST_LINK_DONE_PULSE: assert property (@(posedge i_clk_link) disable iff (!link_rst_n)
		o_link_done |=> !o_link_done)
		else $error("link answer stood more than one cycle");

endmodule // gpx_regs_irq

// *** testbench/gpx_link_master.sv ***
// link-side master model issuing single-byte register accesses
`timescale 1ns/10ps

module gpx_link_master (
	input wire logic i_clk_link,
	input wire logic i_link_busy,
	input wire logic i_link_done,
	input wire gpx_pkg::gpx_byte_t i_link_rdata,
	output logic o_link_req,
	output logic o_link_write,
	output gpx_pkg::gpx_byte_t o_link_addr,
	output gpx_pkg::gpx_byte_t o_link_wdata
);
	initial begin
		o_link_req = 1'b0;
		o_link_write = 1'b0;
		o_link_addr = 8'h00;
		o_link_wdata = 8'h00;
	end

	// one access; gap adds idle link cycles so the far side can be slow too
	task automatic access(input logic wr, input gpx_pkg::gpx_byte_t addr, input gpx_pkg::gpx_byte_t wdata,
		input int gap, output gpx_pkg::gpx_byte_t rdata, output logic ok);
		int n;
		n = 0;
		repeat (gap + 1) @(posedge i_clk_link);
		while (i_link_busy !== 1'b0 && n < 60) begin
			@(posedge i_clk_link);
			n++;
		end
		o_link_req <= 1'b1;
		o_link_write <= wr;
		o_link_addr <= addr;
		o_link_wdata <= wdata;
		@(posedge i_clk_link);
		o_link_req <= 1'b0;
		// released qualifiers flip so stale values never look valid
		o_link_write <= ~wr;
		o_link_addr <= ~addr;
		o_link_wdata <= ~wdata;
		n = 0;
		do begin
			@(posedge i_clk_link);
			n++;
		end while (i_link_done !== 1'b1 && n < 60);
		rdata = i_link_rdata;
		ok = (i_link_done === 1'b1);
	endtask
endmodule // gpx_link_master

// *** testbench/gpx_regs_irq_tb.sv ***
// self-checking bench of the gpio expander register file and interrupts
`timescale 1ns/10ps
`include "gpx_params.svh"

module gpx_regs_irq_tb;
	logic i_clk_sys = 1'b0;
	logic i_clk_link = 1'b0;
	logic i_rst_n = 1'b0;
	gpx_pkg::gpx_byte_t i_io_pins = 8'h00;
	logic link_req, link_write, link_busy, link_done, irq_out, irq_oe_n, ok;
	gpx_pkg::gpx_byte_t link_addr, link_wdata, link_rdata, pins_out, pins_oe_n, pullup_en, rsp;
	gpx_pkg::gpx_byte_t rst_tab [1:11] = '{`GPX_RST_OUTPUT_LEVEL, `GPX_RST_INPUT_POLARITY_INVERT,
		`GPX_RST_PIN_DIRECTION, `GPX_RST_PULLUP_ENABLE, `GPX_RST_IRQ_ENABLE, `GPX_RST_OUTPUT_HIZ_CONTROL,
		`GPX_RST_IRQ_PENDING, `GPX_RST_RISE_EDGE_SELECT, `GPX_RST_FALL_EDGE_SELECT,
		`GPX_RST_GLITCH_FILTER_ENABLE, `GPX_UNMAPPED_READ};
	int fails = 0;
	int num_checks = 0;

	always #50 i_clk_sys = ~i_clk_sys;
	initial begin
		#13;
		forever #24 i_clk_link = ~i_clk_link;
	end

	gpx_regs_irq dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_link(i_clk_link), .i_link_req(link_req),
		.i_link_write(link_write), .i_link_addr(link_addr), .i_link_wdata(link_wdata), .o_link_busy(link_busy),
		.o_link_done(link_done), .o_link_rdata(link_rdata), .i_io_pins(i_io_pins), .o_io_pins_out(pins_out),
		.o_io_pins_oe_n(pins_oe_n), .o_pullup_en(pullup_en), .o_irq_out(irq_out), .o_irq_oe_n(irq_oe_n));

	gpx_link_master master (.i_clk_link(i_clk_link), .i_link_busy(link_busy), .i_link_done(link_done),
		.i_link_rdata(link_rdata), .o_link_req(link_req), .o_link_write(link_write), .o_link_addr(link_addr),
		.o_link_wdata(link_wdata));

	task automatic check_byte(input gpx_pkg::gpx_byte_t got, input gpx_pkg::gpx_byte_t exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// a missing answer counts as a failed byte compare
	task automatic acc(input logic wr, input gpx_pkg::gpx_byte_t addr, input gpx_pkg::gpx_byte_t wdata);
		master.access(wr, addr, wdata, addr[0] ? 3 : 0, rsp, ok);
		if (ok !== 1'b1) begin
			check_byte(8'h00, 8'h01);
		end
	endtask

	task automatic reg_wr(input gpx_pkg::gpx_byte_t addr, input gpx_pkg::gpx_byte_t data);
		acc(1'b1, addr, data);
	endtask

	task automatic reg_rd(input gpx_pkg::gpx_byte_t addr, input gpx_pkg::gpx_byte_t exp);
		acc(1'b0, addr, 8'h00);
		check_byte(rsp, exp);
	endtask

	// pins change at a sys edge, then hold for n further edges
	task automatic pins_for(input gpx_pkg::gpx_byte_t v, input int n);
		@(posedge i_clk_sys);
		i_io_pins <= v;
		repeat (n) @(posedge i_clk_sys);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fails++;
		$display("mismatch at %0t: got %h expected %h", $time, 8'h00, 8'h01);
		stop_test();
	end

	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk_link);
		for (int i = 1; i <= 11; i++) reg_rd(i[7:0], rst_tab[i]);
		check_byte(pins_oe_n, 8'hFF);
		check_byte(pins_out, 8'hFF);
		check_byte(pullup_en, 8'h00);
		check_bit(irq_oe_n, 1'b1);
		check_bit(irq_out, 1'b0);
		$display("test reset_values done");
		for (int i = 1; i <= 10; i++) if (i != 7) reg_wr(i[7:0], 8'hA5 ^ i[7:0]);
		for (int i = 1; i <= 10; i++) if (i != 7) reg_rd(i[7:0], 8'hA5 ^ i[7:0]);
		check_byte(pins_out, 8'hA4);
		check_byte(pullup_en, 8'hA1);
		check_byte(pins_oe_n, 8'hA6 | 8'hA3);
		reg_wr(8'h00, 8'hFF);
		reg_rd(8'h01, 8'hA4);
		$display("test register_rw done");
		reg_wr(8'h03, 8'hF0);
		reg_wr(8'h01, 8'h5A);
		reg_wr(8'h02, 8'h30);
		reg_wr(8'h06, 8'h0F);
		pins_for(8'hC3, 5);
		reg_rd(8'h00, 8'hFA);
		check_byte(pins_oe_n, 8'hFF);
		check_byte(pins_out, 8'h5A);
		$display("test pin_state done");
		pins_for(8'h00, 5);
		reg_wr(8'h02, 8'h00);
		reg_wr(8'h06, 8'h00);
		reg_wr(8'h0A, 8'h00);
		reg_wr(8'h08, 8'h0A);
		reg_wr(8'h09, 8'h0C);
		reg_wr(8'h03, 8'h7F);
		reg_wr(8'h05, 8'hBF);
		reg_rd(8'h00, 8'h00);
		reg_rd(8'h07, 8'h00);
		pins_for(8'hFF, 5);
		reg_rd(8'h07, 8'h3B);
		check_bit(irq_oe_n, 1'b0);
		pins_for(8'h00, 5);
		reg_rd(8'h07, 8'h0E);
		reg_wr(8'h00, 8'hFF);
		reg_wr(8'h07, 8'h00);
		reg_rd(8'h07, 8'h0E);
		reg_rd(8'h00, 8'h00);
		reg_rd(8'h07, 8'h00);
		check_bit(irq_oe_n, 1'b1);
		pins_for(8'hFF, 5);
		reg_rd(8'h00, 8'h7F);
		pins_for(8'h00, 5);
		reg_rd(8'h07, 8'h3D);
		reg_rd(8'h00, 8'h00);
		$display("test edge_modes done");
		reg_wr(8'h06, 8'hFF);
		reg_wr(8'h03, 8'h00);
		pins_for(8'hA4, 5);
		reg_rd(8'h00, 8'h5A);
		check_byte(pins_oe_n, 8'hFF);
		check_bit(irq_out, 1'b0);
		$display("test three_state done");
		reg_wr(8'h0A, 8'h01);
		reg_wr(8'h08, 8'h00);
		reg_wr(8'h09, 8'h00);
		reg_wr(8'h03, 8'hFF);
		reg_wr(8'h05, 8'h01);
		// ten cycles high is 1000 ns, still inside the reject band
		pins_for(8'h01, 9);
		pins_for(8'h00, 20);
		reg_rd(8'h07, 8'h00);
		pins_for(8'h01, 20);
		reg_rd(8'h07, 8'h01);
		check_bit(irq_oe_n, 1'b0);
		pins_for(8'h00, 20);
		reg_rd(8'h07, 8'h00);
		$display("test filter done");
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk_link);
		reg_rd(8'h03, 8'hFF);
		reg_rd(8'h0A, 8'hFF);
		check_byte(pins_out, 8'hFF);
		check_bit(irq_oe_n, 1'b1);
		$display("test mid_reset done");
		stop_test();
	end
endmodule // gpx_regs_irq_tb
